// ===== incskip_cfg.svh
`ifndef INCSKIP_CFG_SVH
`define INCSKIP_CFG_SVH

// ==========================================================
// Opcode fields
`define OP_WIDTH          14
`define INC_SKIP_OP_MSB   13
`define INC_SKIP_OP_LSB   8
`define INC_SKIP_OPCODE   6'h0f
`define OR_LIT_OP_MSB     13
`define OR_LIT_OP_LSB     8
`define OR_LIT_OPCODE     6'h38
`define DIR_BIT           7
`define FADDR_MSB         6
`define LIT_MSB           7

// ==========================================================
// Reset values
`define ACC_RESET         8'h00
`define ZFLAG_RESET       1'b0
`define PHASE_RESET       4'h1

`endif

// ===== incskip_pkg.sv
package incskip_pkg;

  // ==========================================================
  // Types
  typedef logic [13:0] opcode_t;
  typedef logic [7:0]  byte_t;
  typedef logic [6:0]  faddr_t;

  typedef enum logic [3:0] {
    PH_Q1 = 4'h1,
    PH_Q2 = 4'h2,
    PH_Q3 = 4'h4,
    PH_Q4 = 4'h8
  } phase_e;

  typedef struct packed {
    logic   inc_skip;
    logic   or_lit;
    logic   to_file;
    faddr_t faddr;
    byte_t  lit;
  } decoded_s;

  typedef struct packed {
    logic   we;
    faddr_t addr;
    byte_t  data;
  } file_wr_s;

endpackage : incskip_pkg

// ===== incskip_decode.sv
`timescale 1ns/1ps
`include "incskip_cfg.svh"

module incskip_decode
  import incskip_pkg::*;
(
  // Instruction in
  input  wire opcode_t  opcode,
  // Decoded fields
  output decoded_s      dec
);

  // ==========================================================
  // Decode
  always_comb begin
    dec          = '0;
    dec.inc_skip = (opcode[`INC_SKIP_OP_MSB:`INC_SKIP_OP_LSB] == `INC_SKIP_OPCODE);
    dec.or_lit   = (opcode[`OR_LIT_OP_MSB:`OR_LIT_OP_LSB] == `OR_LIT_OPCODE);
    dec.to_file  = opcode[`DIR_BIT];
    dec.faddr    = opcode[`FADDR_MSB:0];
    dec.lit      = opcode[`LIT_MSB:0];
  end

endmodule : incskip_decode

// ===== incskip_exec.sv
`timescale 1ns/1ps
`include "incskip_cfg.svh"


module incskip_exec
  import incskip_pkg::*;
(
  // Clock and reset
  input  wire logic    clk,
  input  wire logic    nrst,
  // Instruction fetch
  input  wire opcode_t opcode,
  input  wire logic    opcode_valid,
  // File register read port
  output faddr_t       file_raddr,
  input  wire byte_t   file_rdata,
  // File register write port
  output file_wr_s     file_wr,
  // Core state
  output byte_t        acc,
  output logic         zero_flag,
  output logic         skip_active,
  output phase_e       phase,
  output logic         cycle_done
);

  // ==========================================================
  // Decode
  decoded_s dec;
  decoded_s dec_r;

  incskip_decode u_decode (
    .opcode (opcode),
    .dec    (dec)
  );

  // ==========================================================
  // Helpers
  function automatic logic is_zero(input byte_t v);
    return (v == 8'h00);
  endfunction : is_zero

  // Only increment with d set may touch the file register
  function automatic logic dest_is_file(input decoded_s d);
    return d.inc_skip && d.to_file;
  endfunction : dest_is_file

  // ==========================================================
  // Four-phase sequencer
  // Fixed four clocks per instruction cycle; nothing stalls it
  phase_e phase_r;
  phase_e phase_nxt;
  logic   busy_r;

  always_comb begin
    case (phase_r)
      PH_Q1:   phase_nxt = PH_Q2;
      PH_Q2:   phase_nxt = PH_Q3;
      PH_Q3:   phase_nxt = PH_Q4;
      PH_Q4:   phase_nxt = PH_Q1;
      default: phase_nxt = PH_Q1;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase_r <= phase_e'(`PHASE_RESET);
    end else begin
      phase_r <= phase_nxt;
    end
  end

  // ==========================================================
  // Fetch latch in Q1; held stable for the whole cycle
  logic skip_r;
  logic take;

  // Words offered outside Q1 are ignored
  assign take = (phase_r == PH_Q1) && opcode_valid;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dec_r <= '0;
    end else if (phase_r == PH_Q1) begin
      // Skipped slot decodes as no-op; fetched word is thrown away
      dec_r <= (take && !skip_r) ? dec : '0;
    end
  end

  // Marks a slot that took a word; idle slots leave a pending skip alone
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy_r <= 1'b0;
    end else if (phase_r == PH_Q1) begin
      busy_r <= take;
    end
  end

  // ==========================================================
  // Operand read in Q2, process in Q3
  byte_t file_rd_r;
  byte_t result_r;
  byte_t acc_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      file_rd_r <= `ACC_RESET;
    end else if (phase_r == PH_Q2) begin
      file_rd_r <= file_rdata;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      result_r <= `ACC_RESET;
    end else if (phase_r == PH_Q3) begin
      if (dec_r.inc_skip) begin
        // Carry dropped on purpose: ff wraps to 00 and arms the skip
        result_r <= byte_t'(file_rd_r + 8'h01);
      end else begin
        result_r <= acc_r | dec_r.lit;
      end
    end
  end

  // ==========================================================
  // Write to destination in Q4
  logic     zero_r;
  file_wr_s file_wr_r;
  faddr_t   file_raddr_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      acc_r <= `ACC_RESET;
    end else if (phase_r == PH_Q4) begin
      if (dec_r.inc_skip && !dest_is_file(dec_r)) begin
        acc_r <= result_r;
      end else if (dec_r.or_lit) begin
        acc_r <= result_r;
      end
    end
  end

  // Increment never touches the flag, so only OR-literal writes it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      zero_r <= `ZFLAG_RESET;
    end else if (phase_r == PH_Q4 && dec_r.or_lit) begin
      zero_r <= is_zero(result_r);
    end
  end

  // One-cycle write strobe during Q1 of the following cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      file_wr_r <= '0;
    end else begin
      file_wr_r.we <= (phase_r == PH_Q4) && dest_is_file(dec_r);
      // Address and data only move at Q4, so they sit still around the strobe
      if (phase_r == PH_Q4) begin
        file_wr_r.addr <= dec_r.faddr;
        file_wr_r.data <= result_r;
      end
    end
  end

  // Address follows the offered word even when it is not an increment
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      file_raddr_r <= '0;
    end else if (phase_r == PH_Q1) begin
      file_raddr_r <= dec.faddr;
    end
  end

  // ==========================================================
  // Skip flag: armed in Q4, consumed by the next fetch
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      skip_r <= 1'b0;
    end else if (phase_r == PH_Q4 && busy_r) begin
      // Idle slot keeps a pending skip; only a taken word consumes it
      skip_r <= dec_r.inc_skip && is_zero(result_r);
    end else if (phase_r == PH_Q1 && take) begin
      // Cleared only once a slot was really spent on the no-op
      skip_r <= 1'b0;
    end
  end

  // ==========================================================
  // Registered outputs
  logic done_r;
  logic skip_out_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      done_r     <= 1'b0;
      skip_out_r <= 1'b0;
    end else begin
      done_r     <= (phase_r == PH_Q4) && busy_r;
      skip_out_r <= skip_r;
    end
  end

  // ==========================================================
  // Port drive
  assign acc         = acc_r;
  assign zero_flag   = zero_r;
  assign skip_active = skip_out_r;
  assign phase       = phase_r;
  assign cycle_done  = done_r;
  assign file_wr     = file_wr_r;
  assign file_raddr  = file_raddr_r;

endmodule : incskip_exec

// ===== incskip_exec_monitor.sv
`timescale 1ns/1ps
module incskip_monitor
  import incskip_pkg::*;
(
  // Watched ports
  input wire logic     clk,
  input wire logic     nrst,
  input wire opcode_t  opcode,
  input wire logic     opcode_valid,
  input wire faddr_t   file_raddr,
  input wire byte_t    file_rdata,
  input wire file_wr_s file_wr,
  input wire byte_t    acc,
  input wire logic     zero_flag,
  input wire logic     skip_active,
  input wire phase_e   phase,
  input wire logic     cycle_done
);
  // ==========
  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  inc_acc_a: assert property (cycle_done && !$past(skip_active,3) &&
    $past(opcode[13:7],4) == 7'h1e |-> !file_wr.we && acc == $past(file_rdata,3) + 8'h01)
    else $error("inc to acc wrong");
  inc_file_a: assert property (file_wr.we |-> $past(opcode[13:7],4) == 7'h1f &&
    file_wr.addr == $past(opcode[6:0],4) && file_wr.data == $past(file_rdata,3) + 8'h01)
    else $error("file write wrong");
  skip_set_a: assert property (cycle_done && !$past(skip_active,3) &&
    $past(opcode[13:8],4) == 6'h0f |=> skip_active == ($past(file_rdata,4) == 8'hff))
    else $error("skip decision wrong");
  skip_noop_a: assert property (cycle_done && $past(skip_active,3) |->
    acc == $past(acc,4) && !file_wr.we && zero_flag == $past(zero_flag,4))
    else $error("discarded slot acted");
  inc_flags_a: assert property (cycle_done &&
    $past(opcode[13:8],4) == 6'h0f |-> zero_flag == $past(zero_flag,4))
    else $error("increment touched flag");
  or_lit_a: assert property (cycle_done && !$past(skip_active,3) &&
    $past(opcode[13:8],4) == 6'h38 |-> acc == ($past(acc,4) | $past(opcode[7:0],4)))
    else $error("or literal wrong");
  or_zero_a: assert property (cycle_done && !$past(skip_active,3) &&
    $past(opcode[13:8],4) == 6'h38 |-> zero_flag == (acc == 8'h00))
    else $error("zero flag wrong");
  // Skip only after a completed slot
  skip_src_a: assert property ($rose(skip_active) |-> $past(cycle_done))
    else $error("skip without cause");

  cover property (file_wr.we);
  cover property (skip_active && !opcode_valid && !cycle_done);
  cover property (cycle_done && skip_active);
  cover property ($rose(zero_flag));
endmodule : incskip_monitor

bind incskip_exec incskip_monitor mon (.clk(clk), .nrst(nrst), .opcode(opcode),
  .opcode_valid(opcode_valid), .file_raddr(file_raddr), .file_rdata(file_rdata),
  .file_wr(file_wr), .acc(acc), .zero_flag(zero_flag), .skip_active(skip_active),
  .phase(phase), .cycle_done(cycle_done));

// ===== tb.sv
`timescale 1ns/1ps
module tb;
  import incskip_pkg::*;
`define CHK(n,e,g) begin n_checks++; if ((g) !== (e)) begin fails++; \
  $display("Error %s exp %h got %h", n, e, g); end end
  // ==========
  // Signals
  logic     clk = 0, nrst = 0, opcode_valid = 0;
  opcode_t  opcode = '0;
  byte_t    file_rdata = '0, acc;
  faddr_t   file_raddr;
  file_wr_s file_wr, wr;
  logic     zero_flag, skip_active, cycle_done;
  phase_e   phase;
  int       fails = 0, n_checks = 0, nwr = 0;

  incskip_exec DUT (.clk(clk), .nrst(nrst), .opcode(opcode), .opcode_valid(opcode_valid),
    .file_raddr(file_raddr), .file_rdata(file_rdata), .file_wr(file_wr), .acc(acc),
    .zero_flag(zero_flag), .skip_active(skip_active), .phase(phase), .cycle_done(cycle_done));

  initial forever #5 clk = ~clk;
  always @(negedge clk) if (file_wr.we === 1'b1) begin
    nwr++;
    wr = file_wr;
  end

  // ==========
  // Tasks
  // One word per 4-clk slot, driven on the falling edge
  task issue(input opcode_t op, input byte_t rd);
    opcode = op;
    file_rdata = rd;
    opcode_valid = 1'b1;
    repeat (4) @(negedge clk);
  endtask : issue
  task t_or_zero;
    issue(14'h3800, 8'h00);
    `CHK("acc", 8'h00, acc)
    `CHK("zf", 1'b1, zero_flag)
    `CHK("phase", PH_Q1, phase)
  endtask : t_or_zero
  task t_inc;
    issue(14'h0f05, 8'h0f);
    `CHK("acc", 8'h10, acc)
    `CHK("nwr", 0, nwr)
    issue(14'h0f83, 8'h41);
    `CHK("acc", 8'h10, acc)
    `CHK("zf", 1'b1, zero_flag)
    `CHK("raddr", 7'h03, file_raddr)
    issue(14'h3800, 8'h00);
    `CHK("nwr", 1, nwr)
    `CHK("addr", 7'h03, wr.addr)
    `CHK("data", 8'h42, wr.data)
    `CHK("zf", 1'b0, zero_flag)
  endtask : t_inc
  task t_skip;
    issue(14'h388a, 8'h00);
    issue(14'h0f87, 8'hff);
    `CHK("done", 1'b1, cycle_done)
    issue(14'h3835, 8'h00);
    `CHK("acc", 8'h9a, acc)
    `CHK("data", 8'h00, wr.data)
    `CHK("addr", 7'h07, wr.addr)
    `CHK("nwr", 2, nwr)
    issue(14'h3835, 8'h00);
    `CHK("acc", 8'hbf, acc)
    `CHK("zf", 1'b0, zero_flag)
  endtask : t_skip
  // A pending skip must survive an idle slot and eat the next real word
  task t_idle_skip;
    issue(14'h0f80, 8'hff);
    opcode_valid = 1'b0;
    repeat (4) @(negedge clk);
    `CHK("skip", 1'b1, skip_active)
    issue(14'h3840, 8'h00);
    `CHK("acc", 8'hbf, acc)
    issue(14'h3840, 8'h00);
    `CHK("acc", 8'hff, acc)
    `CHK("zf", 1'b0, zero_flag)
  endtask : t_idle_skip
  task give_verdict;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  initial begin
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    t_or_zero();
    t_inc();
    t_skip();
    t_idle_skip();
    give_verdict();
  end
  // Hang guard
  initial begin
    #100000;
    fails++;
    give_verdict();
  end
endmodule : tb
